//--- shared/svm_map.svh
// constants of the supply monitor fault logic: timing, register map, field positions
// assumes inclusion by bare name from the design files
`ifndef SVM_MAP_SVH
`define SVM_MAP_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SVM_CLK_PERIOD_NS 10
`define SVM_DGL_RAIL_NS 21000
`define SVM_DGL_FAST_NS 10000
`define SVM_DGL_VIN_UV_NS 90000
`define SVM_ST_STEP_CYC 8
`define SVM_ST_PHASES 8

// ----------------------------------------------------------------
// rails
// ----------------------------------------------------------------
`define SVM_NUM_RAILS 8
`define SVM_RAIL_PRE 0
`define SVM_RAIL_LVR 1
`define SVM_RAIL_BOOST 2
`define SVM_RAIL_VREG 3
`define SVM_RAIL_VIO 4
`define SVM_RAIL_VIN 5
`define SVM_RAIL_EXT0 6
`define SVM_RAIL_EXT1 7
`define SVM_NUM_REG_RAILS 3

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define SVM_ADDR_UV_STAT 12'h000
`define SVM_ADDR_OV_STAT 12'h004
`define SVM_ADDR_PROT_STAT 12'h008
`define SVM_ADDR_CTRL 12'h00c
`define SVM_ADDR_TEST 12'h010
`define SVM_ADDR_IRQ_STAT 12'h014
`define SVM_ADDR_IRQ_MASK 12'h018

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define SVM_CTRL_UV_RST_LSB 0
`define SVM_CTRL_OV_RST_LSB 3
`define SVM_CTRL_VIN_IRQ_BIT 6
`define SVM_CTRL_RESET 7'h00
`define SVM_TEST_START_BIT 0
`define SVM_TEST_BUSY_BIT 0
`define SVM_TEST_PASS_BIT 1
`define SVM_TEST_FAIL_BIT 2
`define SVM_IRQ_UV_BIT 0
`define SVM_IRQ_OV_BIT 1
`define SVM_IRQ_PROT_BIT 2
`define SVM_IRQ_TEST_BIT 3
`define SVM_IRQ_WIDTH 4
`define SVM_IRQ_RESET 4'h0

`endif

//--- shared/svm_pkg.sv
// types of the supply monitor fault logic
// assumes svm_map.svh for the numbers
package svm_pkg;

  // ----------------------------------------------------------------
  // comparator group: one bit per rail for each kind of fault
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] prot;
    logic [7:0] ov;
    logic [7:0] uv;
  } svm_cmp_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } svm_apb_req_t;

  typedef enum logic [2:0] {
    SVM_DEV_OFF = 3'b000,
    SVM_DEV_RESET = 3'b001,
    SVM_DEV_DIAG = 3'b010,
    SVM_DEV_ACTIVE = 3'b011,
    SVM_DEV_SAFE = 3'b100
  } svm_dev_state_t;

  typedef enum logic [1:0] {
    SVM_ST_IDLE = 2'b00,
    SVM_ST_RUN = 2'b01
  } svm_st_state_t;

endpackage : svm_pkg

//--- logic/svm_rail_flag.sv
// one fault flag of one rail: deglitch counter and sticky flag
// assumes cond_in already synchronised to clk_in
`timescale 1ns/100ps
module svm_rail_flag #(
  parameter int DGL_CYC = 2100
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic cond_in,
  input wire logic ramping_in,
  input wire logic test_active_in,
  input wire logic clear_in,
  output logic flag_out,
  output logic set_pulse_out
);
  localparam logic [13:0] LIMIT = 14'(DGL_CYC);
  localparam logic [13:0] LAST = 14'(DGL_CYC - 1);

  logic [13:0] cnt_q;
  logic [13:0] cnt_d;
  logic flag_q;
  logic flag_d;
  logic set_d;

  always_comb begin
    cnt_d = cnt_q;
    flag_d = flag_q;
    set_d = 1'b0;
    if (ramping_in) begin
      cnt_d = 14'h0000; // RULE3
      flag_d = 1'b0; // RULE3
    end else if (cond_in && !test_active_in) begin // RULE11
      if (cnt_q == LAST) begin
        cnt_d = LIMIT; // RULE6
        set_d = 1'b1; // RULE4
      end else if (cnt_q != LIMIT) begin
        cnt_d = cnt_q + 14'h0001; // RULE6
      end
      if (cnt_q == LAST || cnt_q == LIMIT) begin
        flag_d = 1'b1; // RULE4
      end
    end else begin
      cnt_d = 14'h0000; // RULE6
      if (clear_in && !cond_in) begin
        flag_d = 1'b0; // RULE5
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_q <= 14'h0000;
      flag_q <= 1'b0;
      set_pulse_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      flag_q <= flag_d;
      set_pulse_out <= set_d;
    end
  end

  assign flag_out = flag_q;

endmodule : svm_rail_flag

//--- logic/svm_fault_logic.sv
// supply monitor fault logic: per-rail flags, self-test, pin and state responses, apb
// assumes raw comparator and ramp signals are asynchronous; device state is on clk_in
//
// Behaviour
// RULE1: watch input supply, regulators, internal regulators and two external rails.
// RULE2: separate readable undervoltage, overvoltage and protection flags per rail.
// RULE3: flags of a ramping rail are held at zero.
// RULE4: out-of-window condition lasting the deglitch time sets its flag.
// RULE5: set flag stays until a read clears it with the fault gone.
// RULE6: each rail has its own deglitch timer; short glitches change nothing.
// RULE7: monitoring never stops, even with the feeding regulator off.
// RULE8: self-test at power-up; host start only in diagnostic, active, safe.
// RULE9: self-test toggles every comparator several times through emulated faults.
// RULE10: toggling pattern of each comparator is checked for pass or fail.
// RULE11: self-test disturbs no rail and records no fault events.
// RULE12: regulator reset enable selects reset request and low reset pin.
// RULE13: any fault drives interrupt pin low; input undervoltage only when enabled.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`include "svm_map.svh"
module svm_fault_logic #(
  parameter int VIN_UV_DGL_CYC = `SVM_DGL_VIN_UV_NS / `SVM_CLK_PERIOD_NS
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire svm_pkg::svm_apb_req_t apb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire svm_pkg::svm_cmp_t cmp_in,
  input wire logic [7:0] ramping_in,
  input wire svm_pkg::svm_dev_state_t device_state_in,
  output svm_pkg::svm_cmp_t test_drive_out,
  output logic test_active_out,
  output logic reset_output_pin_n_out,
  output logic enable_interrupt_pin_n_out,
  output logic req_reset_out,
  output logic req_safe_out,
  output logic irq_out
);
  // least times round up to whole cycles
  localparam int RAIL_DGL_CYC = (`SVM_DGL_RAIL_NS + `SVM_CLK_PERIOD_NS - 1) / `SVM_CLK_PERIOD_NS;
  localparam int FAST_DGL_CYC = (`SVM_DGL_FAST_NS + `SVM_CLK_PERIOD_NS - 1) / `SVM_CLK_PERIOD_NS;
  localparam logic [3:0] STEP_LAST = 4'(`SVM_ST_STEP_CYC - 1);
  localparam logic [3:0] PHASE_LAST = 4'(`SVM_ST_PHASES - 1);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  svm_pkg::svm_cmp_t cmp_meta_q;
  svm_pkg::svm_cmp_t cmp_sync_q;
  logic [7:0] ramp_meta_q;
  logic [7:0] ramp_sync_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cmp_meta_q <= '0;
      cmp_sync_q <= '0;
      ramp_meta_q <= 8'h00;
      ramp_sync_q <= 8'h00;
    end else begin
      cmp_meta_q <= cmp_in;
      cmp_sync_q <= cmp_meta_q;
      ramp_meta_q <= ramping_in;
      ramp_sync_q <= ramp_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_w;
  logic access_w;
  logic wr_w;
  logic rd_w;
  logic mapped_w;

  assign setup_w = apb_in.psel && !apb_in.penable;
  assign access_w = apb_in.psel && apb_in.penable;
  assign wr_w = access_w && apb_in.pwrite;
  assign rd_w = access_w && !apb_in.pwrite;

  always_comb begin
    unique case (apb_in.paddr)
      `SVM_ADDR_UV_STAT, `SVM_ADDR_OV_STAT, `SVM_ADDR_PROT_STAT, `SVM_ADDR_CTRL,
      `SVM_ADDR_TEST, `SVM_ADDR_IRQ_STAT, `SVM_ADDR_IRQ_MASK: mapped_w = 1'b1;
      default: mapped_w = 1'b0;
    endcase
  end

  assign pready_out = access_w;
  assign pslverr_out = access_w && !mapped_w;

  // read clears of the sticky flags take effect at the access edge
  logic clr_uv_w;
  logic clr_ov_w;
  logic clr_prot_w;

  assign clr_uv_w = rd_w && (apb_in.paddr == `SVM_ADDR_UV_STAT); // RULE5
  assign clr_ov_w = rd_w && (apb_in.paddr == `SVM_ADDR_OV_STAT); // RULE5
  assign clr_prot_w = rd_w && (apb_in.paddr == `SVM_ADDR_PROT_STAT); // RULE5

  // ----------------------------------------------------------------
  // per-rail flags
  // ----------------------------------------------------------------
  svm_pkg::svm_cmp_t flag_w;
  svm_pkg::svm_cmp_t set_w;
  logic st_active_w;

  // monitoring runs whatever the device state or regulator enables
  for (genvar r = 0; r < `SVM_NUM_RAILS; r++) begin : g_rail // RULE1 RULE7
    localparam int UV_CYC = (r == `SVM_RAIL_VIN) ? VIN_UV_DGL_CYC : RAIL_DGL_CYC;
    localparam bit FAST_OV = (r == `SVM_RAIL_VIN) || (r == `SVM_RAIL_VREG) ||
                             (r == `SVM_RAIL_VIO);
    localparam int OV_CYC = FAST_OV ? FAST_DGL_CYC : RAIL_DGL_CYC;

    svm_rail_flag #(.DGL_CYC(UV_CYC)) u_uv ( // RULE2
      .clk_in(clk_in),
      .reset_in(reset_in),
      .cond_in(cmp_sync_q.uv[r]),
      .ramping_in(ramp_sync_q[r]),
      .test_active_in(st_active_w),
      .clear_in(clr_uv_w),
      .flag_out(flag_w.uv[r]),
      .set_pulse_out(set_w.uv[r])
    );
    svm_rail_flag #(.DGL_CYC(OV_CYC)) u_ov ( // RULE2
      .clk_in(clk_in),
      .reset_in(reset_in),
      .cond_in(cmp_sync_q.ov[r]),
      .ramping_in(ramp_sync_q[r]),
      .test_active_in(st_active_w),
      .clear_in(clr_ov_w),
      .flag_out(flag_w.ov[r]),
      .set_pulse_out(set_w.ov[r])
    );
    svm_rail_flag #(.DGL_CYC(RAIL_DGL_CYC)) u_prot ( // RULE2
      .clk_in(clk_in),
      .reset_in(reset_in),
      .cond_in(cmp_sync_q.prot[r]),
      .ramping_in(ramp_sync_q[r]),
      .test_active_in(st_active_w),
      .clear_in(clr_prot_w),
      .flag_out(flag_w.prot[r]),
      .set_pulse_out(set_w.prot[r])
    );
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [6:0] ctrl_q;
  logic [6:0] ctrl_d;
  logic [`SVM_IRQ_WIDTH-1:0] irq_mask_q;
  logic [`SVM_IRQ_WIDTH-1:0] irq_mask_d;
  logic [2:0] uv_rst_en_w;
  logic [2:0] ov_rst_en_w;
  logic vin_irq_en_w;

  always_comb begin
    ctrl_d = ctrl_q;
    irq_mask_d = irq_mask_q;
    if (wr_w && apb_in.paddr == `SVM_ADDR_CTRL) begin
      ctrl_d = apb_in.pwdata[6:0];
    end
    if (wr_w && apb_in.paddr == `SVM_ADDR_IRQ_MASK) begin
      irq_mask_d = apb_in.pwdata[`SVM_IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q <= `SVM_CTRL_RESET;
      irq_mask_q <= `SVM_IRQ_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  assign uv_rst_en_w = ctrl_q[`SVM_CTRL_UV_RST_LSB +: `SVM_NUM_REG_RAILS];
  assign ov_rst_en_w = ctrl_q[`SVM_CTRL_OV_RST_LSB +: `SVM_NUM_REG_RAILS];
  assign vin_irq_en_w = ctrl_q[`SVM_CTRL_VIN_IRQ_BIT];

  // ----------------------------------------------------------------
  // self-test controller
  // ----------------------------------------------------------------
  svm_pkg::svm_st_state_t st_q;
  svm_pkg::svm_st_state_t st_d;
  logic st_pending_q;
  logic st_pending_d;
  logic [3:0] step_q;
  logic [3:0] step_d;
  logic [3:0] phase_q;
  logic [3:0] phase_d;
  logic pat_q;
  logic pat_d;
  logic st_fail_q;
  logic st_fail_d;
  logic st_pass_q;
  logic st_pass_d;
  logic st_done_d;
  logic st_done_q;
  logic host_start_w;
  logic state_ok_w;

  assign state_ok_w = (device_state_in == svm_pkg::SVM_DEV_DIAG) ||
                      (device_state_in == svm_pkg::SVM_DEV_ACTIVE) ||
                      (device_state_in == svm_pkg::SVM_DEV_SAFE);
  assign host_start_w = wr_w && (apb_in.paddr == `SVM_ADDR_TEST) &&
                        apb_in.pwdata[`SVM_TEST_START_BIT] && state_ok_w; // RULE8

  always_comb begin
    st_d = st_q;
    st_pending_d = st_pending_q;
    step_d = step_q;
    phase_d = phase_q;
    pat_d = pat_q;
    st_fail_d = st_fail_q;
    st_pass_d = st_pass_q;
    st_done_d = 1'b0;
    unique case (st_q)
      svm_pkg::SVM_ST_IDLE: begin
        if (st_pending_q || host_start_w) begin // RULE8
          st_d = svm_pkg::SVM_ST_RUN;
          st_pending_d = 1'b0;
          step_d = 4'h0;
          phase_d = 4'h0;
          pat_d = 1'b1;
          st_fail_d = 1'b0;
          st_pass_d = 1'b0;
        end
      end
      svm_pkg::SVM_ST_RUN: begin
        if (step_q == STEP_LAST) begin
          step_d = 4'h0;
          if (cmp_sync_q != {$bits(svm_pkg::svm_cmp_t){pat_q}}) begin
            st_fail_d = 1'b1; // RULE10
          end
          pat_d = !pat_q; // RULE9
          if (phase_q == PHASE_LAST) begin
            st_d = svm_pkg::SVM_ST_IDLE;
            pat_d = 1'b0;
            st_done_d = 1'b1;
            st_pass_d = !st_fail_d; // RULE10
          end else begin
            phase_d = phase_q + 4'h1;
          end
        end else begin
          step_d = step_q + 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_q <= svm_pkg::SVM_ST_IDLE;
      st_pending_q <= 1'b1; // RULE8
      step_q <= 4'h0;
      phase_q <= 4'h0;
      pat_q <= 1'b0;
      st_fail_q <= 1'b0;
      st_pass_q <= 1'b0;
      st_done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      st_pending_q <= st_pending_d;
      step_q <= step_d;
      phase_q <= phase_d;
      pat_q <= pat_d;
      st_fail_q <= st_fail_d;
      st_pass_q <= st_pass_d;
      st_done_q <= st_done_d;
    end
  end

  // emulation reaches only the comparator inputs; flags ignore them meanwhile
  assign st_active_w = (st_q == svm_pkg::SVM_ST_RUN); // RULE11
  assign test_active_out = st_active_w;
  assign test_drive_out = {$bits(svm_pkg::svm_cmp_t){pat_q}}; // RULE9

  // ----------------------------------------------------------------
  // responses: state requests and pins
  // ----------------------------------------------------------------
  logic rst_ev_w;
  logic safe_ev_w;
  logic rst_hold_w;
  logic irq_hold_w;
  svm_pkg::svm_cmp_t irq_src_w;
  logic req_reset_q;
  logic req_safe_q;
  logic rst_pin_n_q;
  logic int_pin_n_q;

  assign rst_ev_w = |(set_w.uv[2:0] & uv_rst_en_w) | |(set_w.ov[2:0] & ov_rst_en_w); // RULE12
  assign safe_ev_w = |(set_w.uv[2:0] & ~uv_rst_en_w) | |(set_w.ov[2:0] & ~ov_rst_en_w) |
                     |set_w.prot[2:0]; // RULE12
  assign rst_hold_w = |(flag_w.uv[2:0] & uv_rst_en_w) | |(flag_w.ov[2:0] & ov_rst_en_w);

  always_comb begin
    irq_src_w = flag_w;
    irq_src_w.uv[`SVM_RAIL_VIN] = flag_w.uv[`SVM_RAIL_VIN] && vin_irq_en_w; // RULE13
  end
  assign irq_hold_w = |irq_src_w; // RULE13

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      req_reset_q <= 1'b0;
      req_safe_q <= 1'b0;
      rst_pin_n_q <= 1'b1;
      int_pin_n_q <= 1'b1;
    end else begin
      req_reset_q <= rst_ev_w; // RULE12
      req_safe_q <= safe_ev_w && !rst_ev_w; // RULE12
      rst_pin_n_q <= !rst_hold_w; // RULE12
      int_pin_n_q <= !irq_hold_w; // RULE13
    end
  end

  assign req_reset_out = req_reset_q;
  assign req_safe_out = req_safe_q;
  assign reset_output_pin_n_out = rst_pin_n_q;
  assign enable_interrupt_pin_n_out = int_pin_n_q;

  // ----------------------------------------------------------------
  // interrupt status and read data
  // ----------------------------------------------------------------
  logic [`SVM_IRQ_WIDTH-1:0] irq_stat_q;
  logic [`SVM_IRQ_WIDTH-1:0] irq_stat_d;
  logic [`SVM_IRQ_WIDTH-1:0] irq_ev_w;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  assign irq_ev_w[`SVM_IRQ_UV_BIT] = |set_w.uv;
  assign irq_ev_w[`SVM_IRQ_OV_BIT] = |set_w.ov;
  assign irq_ev_w[`SVM_IRQ_PROT_BIT] = |set_w.prot;
  assign irq_ev_w[`SVM_IRQ_TEST_BIT] = st_done_q;

  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_w && apb_in.paddr == `SVM_ADDR_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~apb_in.pwdata[`SVM_IRQ_WIDTH-1:0];
    end
    irq_stat_d = irq_stat_d | irq_ev_w; // set wins over clear
    rdata_d = rdata_q;
    if (setup_w) begin
      rdata_d = 32'h0000_0000;
      unique case (apb_in.paddr)
        `SVM_ADDR_UV_STAT: rdata_d[7:0] = flag_w.uv; // RULE2
        `SVM_ADDR_OV_STAT: rdata_d[7:0] = flag_w.ov; // RULE2
        `SVM_ADDR_PROT_STAT: rdata_d[7:0] = flag_w.prot; // RULE2
        `SVM_ADDR_CTRL: rdata_d[6:0] = ctrl_q;
        `SVM_ADDR_TEST: begin
          rdata_d[`SVM_TEST_BUSY_BIT] = st_active_w;
          rdata_d[`SVM_TEST_PASS_BIT] = st_pass_q;
          rdata_d[`SVM_TEST_FAIL_BIT] = st_fail_q;
        end
        `SVM_ADDR_IRQ_STAT: rdata_d[`SVM_IRQ_WIDTH-1:0] = irq_stat_q;
        `SVM_ADDR_IRQ_MASK: rdata_d[`SVM_IRQ_WIDTH-1:0] = irq_mask_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_stat_q <= `SVM_IRQ_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      irq_stat_q <= irq_stat_d;
      rdata_q <= rdata_d;
    end
  end

  assign prdata_out = rdata_q;
  assign irq_out = |(irq_stat_q & irq_mask_q);

endmodule : svm_fault_logic

//--- testbench/svm_analog_model.sv
// comparator front end seen by the fault logic: real faults or self-test emulation
// assumes the bench commands faults and a stuck comparator bank
`timescale 1ns/100ps
module svm_analog_model (
  input wire logic clk_in,
  input wire svm_pkg::svm_cmp_t test_drive_in,
  input wire logic test_active_in,
  input wire svm_pkg::svm_cmp_t fault_in,
  input wire logic stuck_in,
  output svm_pkg::svm_cmp_t cmp_out
);
  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (test_active_in) begin
      cmp_out <= stuck_in ? '0 : test_drive_in;
    end else begin
      cmp_out <= fault_in;
    end
  end
endmodule : svm_analog_model

//--- testbench/svm_fault_logic_properties.sv
// timing checks on the ports of the supply monitor fault logic
// assumes the bind below and the map header on the include path
`timescale 1ns/100ps
`include "svm_map.svh"
module svm_fault_checker #(
  parameter int VIN_UV_DGL_CYC = 20
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire svm_pkg::svm_apb_req_t apb_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire svm_pkg::svm_dev_state_t device_state_in,
  input wire svm_pkg::svm_cmp_t test_drive_out,
  input wire logic test_active_out,
  input wire logic reset_output_pin_n_out,
  input wire logic enable_interrupt_pin_n_out,
  input wire logic req_reset_out,
  input wire logic req_safe_out
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [6:0] run_q;
  logic [6:0] run_d;
  logic acc;
  logic mapped;
  assign acc = apb_in.psel && apb_in.penable;
  assign mapped = apb_in.paddr inside {`SVM_ADDR_UV_STAT, `SVM_ADDR_OV_STAT,
    `SVM_ADDR_PROT_STAT, `SVM_ADDR_CTRL, `SVM_ADDR_TEST, `SVM_ADDR_IRQ_STAT,
    `SVM_ADDR_IRQ_MASK};
  always_comb run_d = test_active_out ? run_q + 7'h01 : 7'h00;
  always_ff @(posedge clk_in) run_q <= reset_in ? 7'h00 : run_d;
  sequence start_s;
    acc && apb_in.pwrite && apb_in.paddr == `SVM_ADDR_TEST && apb_in.pwdata[0];
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  ready_tied_a: assert property (pready_out == acc) else $error("ready not tied to access");
  unmapped_err_a: assert property (pslverr_out == (acc && !mapped))
    else $error("error response wrong");
  reset_pulse_a: assert property (req_reset_out |=> !req_reset_out)
    else $error("reset request longer than one cycle");
  safe_pulse_a: assert property (req_safe_out |=> !req_safe_out)
    else $error("safe request longer than one cycle");
  reset_pins_a: assert property (req_reset_out |-> ##[0:1]
    (!reset_output_pin_n_out && !enable_interrupt_pin_n_out)) else $error("pins not low");
  safe_pin_a: assert property (req_safe_out |-> ##[0:1] !enable_interrupt_pin_n_out)
    else $error("interrupt pin not low");
  quiet_test_a: assert property (test_active_out && $past(test_active_out, 2)
    |-> !req_reset_out && !req_safe_out) else $error("request during self-test");
  run_len_a: assert property ($fell(test_active_out) |-> run_q == 7'h40)
    else $error("self-test length wrong");
  drive_even_a: assert property ((&test_drive_out) || !(|test_drive_out))
    else $error("emulation drive bits differ");
  start_refused_a: assert property (start_s ##0 (!test_active_out &&
    device_state_in inside {svm_pkg::SVM_DEV_OFF, svm_pkg::SVM_DEV_RESET})
    |=> !test_active_out) else $error("self-test started in wrong state");
  start_taken_a: assert property (start_s ##0 (device_state_in inside
    {svm_pkg::SVM_DEV_DIAG, svm_pkg::SVM_DEV_ACTIVE, svm_pkg::SVM_DEV_SAFE})
    |-> ##[1:2] test_active_out) else $error("self-test not started");
endmodule : svm_fault_checker

bind svm_fault_logic svm_fault_checker #(.VIN_UV_DGL_CYC(VIN_UV_DGL_CYC)) u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .apb_in(apb_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .device_state_in(device_state_in),
  .test_drive_out(test_drive_out), .test_active_out(test_active_out),
  .reset_output_pin_n_out(reset_output_pin_n_out),
  .enable_interrupt_pin_n_out(enable_interrupt_pin_n_out),
  .req_reset_out(req_reset_out), .req_safe_out(req_safe_out));

//--- testbench/test_svm_fault_logic.sv
// self-checking bench of the supply monitor fault logic over apb
// assumes the analog model loops the self-test drive back to the comparators
`timescale 1ns/100ps
`include "svm_map.svh"
module test_svm_fault_logic;
  logic clk_in;
  logic reset_in;
  svm_pkg::svm_apb_req_t apb_q;
  svm_pkg::svm_cmp_t cmp;
  svm_pkg::svm_cmp_t drv;
  svm_pkg::svm_cmp_t fault_q;
  svm_pkg::svm_dev_state_t state_q;
  logic [31:0] prdata;
  logic [31:0] r;
  logic [7:0] ramp_q;
  logic pready, pslverr, act, rst_n, en_n, irq, stuck_q, e;
  int err_count;
  int comparisons;
  svm_fault_logic #(.VIN_UV_DGL_CYC(20)) dut (.clk_in(clk_in), .reset_in(reset_in),
    .apb_in(apb_q), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .cmp_in(cmp), .ramping_in(ramp_q), .device_state_in(state_q), .test_drive_out(drv),
    .test_active_out(act), .reset_output_pin_n_out(rst_n),
    .enable_interrupt_pin_n_out(en_n), .req_reset_out(), .req_safe_out(), .irq_out(irq));
  svm_analog_model afe (.clk_in(clk_in), .test_drive_in(drv), .test_active_in(act),
    .fault_in(fault_q), .stuck_in(stuck_q), .cmp_out(cmp));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk_w(input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk_w
  task chk_b(input logic exp, input logic got);
    chk_w({31'h0, exp}, {31'h0, got});
  endtask : chk_b
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    apb_q <= {1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    apb_q.penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    apb_q <= '0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_w(exp, r);
  endtask : rd_chk
  task wait_n(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_n
  task note(input string s);
    $display("test %s done", s);
  endtask : note
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    reset_in = 1'b1;
    apb_q = '0;
    fault_q = '0;
    ramp_q = 8'h00;
    stuck_q = 1'b0;
    state_q = svm_pkg::SVM_DEV_SAFE;
    err_count = 0;
    comparisons = 0;
    wait_n(12);
    reset_in <= 1'b0;
    wait_n(90);
    rd_chk(`SVM_ADDR_TEST, 32'h2);
    rd_chk(`SVM_ADDR_IRQ_STAT, 32'h8);
    chk_b(1'b0, irq);
    wr(`SVM_ADDR_IRQ_MASK, 32'h8);
    wait_n(2);
    chk_b(1'b1, irq);
    wr(`SVM_ADDR_IRQ_STAT, 32'h8);
    wait_n(2);
    chk_b(1'b0, irq);
    rd_chk(`SVM_ADDR_CTRL, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk_w(32'h0, r);
    chk_b(1'b1, e);
    note("power-up and registers");
    wr(`SVM_ADDR_CTRL, 32'h1);
    fault_q <= 24'h000002;
    wait_n(1000);
    fault_q <= '0;
    wait_n(10);
    rd_chk(`SVM_ADDR_UV_STAT, 32'h0);
    ramp_q <= 8'h04;
    fault_q <= 24'h000004;
    wait_n(2200);
    rd_chk(`SVM_ADDR_UV_STAT, 32'h0);
    ramp_q <= 8'h00;
    fault_q <= 24'h000001;
    wait_n(2200);
    rd_chk(`SVM_ADDR_UV_STAT, 32'h1);
    chk_b(1'b0, rst_n);
    chk_b(1'b0, en_n);
    rd_chk(`SVM_ADDR_UV_STAT, 32'h1);
    fault_q <= '0;
    wait_n(6);
    rd_chk(`SVM_ADDR_UV_STAT, 32'h1);
    rd_chk(`SVM_ADDR_UV_STAT, 32'h0);
    wait_n(2);
    chk_b(1'b1, rst_n);
    note("deglitch ramp sticky");
    wr(`SVM_ADDR_CTRL, 32'h0);
    fault_q <= 24'h000020;
    wait_n(60);
    rd_chk(`SVM_ADDR_UV_STAT, 32'h20);
    chk_b(1'b1, en_n);
    wr(`SVM_ADDR_CTRL, 32'h40);
    wait_n(3);
    chk_b(1'b0, en_n);
    fault_q <= 24'h024000;
    wait_n(2200);
    rd_chk(`SVM_ADDR_OV_STAT, 32'h40);
    rd_chk(`SVM_ADDR_PROT_STAT, 32'h2);
    rd_chk(`SVM_ADDR_UV_STAT, 32'h20);
    chk_b(1'b1, rst_n);
    fault_q <= '0;
    note("input supply and other flags");
    state_q <= svm_pkg::SVM_DEV_OFF;
    wr(`SVM_ADDR_TEST, 32'h1);
    wait_n(2);
    chk_b(1'b0, act);
    state_q <= svm_pkg::SVM_DEV_ACTIVE;
    stuck_q <= 1'b1;
    wr(`SVM_ADDR_TEST, 32'h1);
    wait_n(2);
    chk_b(1'b1, act);
    wait_n(80);
    stuck_q <= 1'b0;
    rd_chk(`SVM_ADDR_TEST, 32'h4);
    rd_chk(`SVM_ADDR_UV_STAT, 32'h0);
    rd_chk(`SVM_ADDR_IRQ_STAT, 32'hf);
    chk_b(1'b1, irq);
    note("host self-test");
    test_done;
  end
  initial begin
    #300000;
    err_count++;
    test_done;
  end
endmodule : test_svm_fault_logic
